/* File: core/pwmdt_dt_if.sv */
`default_nettype none
interface pwmdt_dt_if import pwmdt_pkg::*; ();
  logic [DLY_W-1:0] delay;
  logic             phase_in;
  logic             out_a;
  logic             out_b;
  modport ctl (output delay, output phase_in, input out_a, input out_b);
  modport gen (input delay, input phase_in, output out_a, output out_b);
endinterface : pwmdt_dt_if
`default_nettype wire

/* File: core/pwmdt_gen.sv */
`default_nettype none
module pwmdt_gen
  import pwmdt_pkg::*;
(
  input wire logic CLK,
  input wire logic RESET_N,
  pwmdt_dt_if.gen  dt
);
  logic [DLY_W-1:0] cnt_a_ff;
  logic [DLY_W-1:0] cnt_b_ff;
  logic [DLY_W-1:0] nxt_cnt_a;
  logic [DLY_W-1:0] nxt_cnt_b;

  // Count high and low time, saturating at the delay
  always_comb begin
    nxt_cnt_a = '0;
    nxt_cnt_b = '0;
    if (dt.phase_in) begin
      nxt_cnt_a = (cnt_a_ff >= dt.delay) ? dt.delay : cnt_a_ff + 1'b1;
    end else begin
      nxt_cnt_b = (cnt_b_ff >= dt.delay) ? dt.delay : cnt_b_ff + 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cnt_a_ff <= '0;
      cnt_b_ff <= '0;
    end else begin
      cnt_a_ff <= nxt_cnt_a;
      cnt_b_ff <= nxt_cnt_b;
    end
  end

  // Rising edges wait out the delay, falling edges follow at once
  assign dt.out_a = dt.phase_in && (cnt_a_ff >= dt.delay);   // [RL4] [RL6]
  assign dt.out_b = !dt.phase_in && (cnt_b_ff >= dt.delay);  // [RL5] [RL6]

  never_both_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL1]
    !(dt.out_a && dt.out_b)) else $error("both switches on");
  a_follows_in_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL4]
    $fell(dt.phase_in) |-> !dt.out_a) else $error("A falling edge delayed");
  a_delay_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL4]
    (dt.phase_in && $stable(dt.delay) && dt.delay == 9'h002 && !$past(dt.phase_in)
     && $past(dt.delay) == 9'h002) |-> !dt.out_a ##1 !dt.out_a
     ##1 (dt.out_a || !dt.phase_in || !$past(dt.phase_in)))
    else $error("A rise not delayed by two cycles");
  b_inverse_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL5]
    dt.out_b |-> !dt.phase_in ##0 $past(!dt.phase_in)) else $error("B not inverse");
  short_pulse_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL6]
    ($rose(dt.phase_in) && dt.delay >= 9'h004) ##1 !dt.phase_in |-> !$past(dt.out_a))
    else $error("short pulse not suppressed");
endmodule : pwmdt_gen
`default_nettype wire

/* File: core/pwmdt_pkg.sv */
`default_nettype none
package pwmdt_pkg;
  // Register byte offsets
  localparam logic [3:0] REG_DEAD_CFG = 4'h0;
  localparam logic [3:0] REG_CTRL     = 4'h4;
  localparam logic [3:0] REG_STATUS   = 4'h8;
  // Reset values
  localparam logic [7:0] DEAD_CFG_RESET = 8'hFF;
  // Control field positions
  localparam int CTRL_DTE  = 0;
  localparam int CTRL_PCN  = 1;
  localparam int CTRL_OSC  = 2;
  localparam int CTRL_OSU  = 3;
  localparam int CTRL_OSZ  = 4;
  localparam int CTRL_SENS = 5;
  localparam int CTRL_VOC  = 6;
  // Status field positions
  localparam int STAT_WIN  = 6;
  localparam int STAT_WR1  = 7;
  // Delay code fields
  localparam int DLY_RANGE = 5;
  localparam int DLY_SCALE = 4;
  localparam logic [8:0] DLY_OFS_FINE   = 9'h001;
  localparam logic [8:0] DLY_OFS_COARSE = 9'h011;
  localparam int DLY_W = 9;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Delay code to clock cycles
  function automatic logic [DLY_W-1:0] pwmdt_delay_cycles(input logic [5:0] code);
    logic [DLY_W-1:0] base;
    base = '0;
    if (!code[DLY_RANGE]) begin
      base = {4'h0, code[4:0]} + DLY_OFS_FINE;
      return DLY_W'(base << 1);
    end
    base = {5'h00, code[3:0]} + DLY_OFS_COARSE;
    return code[DLY_SCALE] ? DLY_W'(base << 3) : DLY_W'(base << 2);
  endfunction : pwmdt_delay_cycles
endpackage : pwmdt_pkg
`default_nettype wire

/* File: core/pwmdt_top.sv */
// Summary of operation
// RL1: Each half bridge gets complementary high and low drives with a guard gap between them.
// RL2: Three independent dead time generators, one per phase, share a 6-bit delay code.
// RL3: In six-step drive the switch beside the PWM one gets the guarded complement.
// RL4: Output A follows the phase input with its rising edge delayed by the dead time.
// RL5: Output B is the inverse of the input with its rising edge delayed after the input falls.
// RL6: A pulse shorter than the delay is dropped and that output stays low.
// RL7: After zero crossing until commutation, side select 0 puts PWM on high, 1 on low.
// RL8: Sensor mode produces no demagnetisation event; PWM side may differ before and after Z.
// RL9: Delay code top bit 0 gives (low5+1)*2 clocks, else (low4+17)*4 or *8 by bit four.
// RL10: The dead time configuration register takes only the first write after reset.
// RL11: The dead time configuration register resets to all ones.
// RL12: Three-PWM mode without dead time drives low sides as plain complements.
// RL13: After commutation until zero crossing, side select 0 puts PWM on high, 1 on low.
//
// The placing of the registers and the AXI4-Lite slave port were decided locally.
`default_nettype none
module pwmdt_top
  import pwmdt_pkg::*;
#(
  parameter int NPH = 3
) (
  input  wire logic          CLK,
  input  wire logic          RESET_N,
  input  wire logic [3:0]    S_AXI_AWADDR,
  input  wire logic          S_AXI_AWVALID,
  output logic               S_AXI_AWREADY,
  input  wire logic [31:0]   S_AXI_WDATA,
  input  wire logic [3:0]    S_AXI_WSTRB,
  input  wire logic          S_AXI_WVALID,
  output logic               S_AXI_WREADY,
  output logic [1:0]         S_AXI_BRESP,
  output logic               S_AXI_BVALID,
  input  wire logic          S_AXI_BREADY,
  input  wire logic [3:0]    S_AXI_ARADDR,
  input  wire logic          S_AXI_ARVALID,
  output logic               S_AXI_ARREADY,
  output logic [31:0]        S_AXI_RDATA,
  output logic [1:0]         S_AXI_RRESP,
  output logic               S_AXI_RVALID,
  input  wire logic          S_AXI_RREADY,
  input  wire logic [NPH-1:0]   PHASE_PWM,
  input  wire logic [2*NPH-1:0] CHAN_ACTIVE,
  input  wire logic          COMMUTATION_EVT,
  input  wire logic          ZERO_CROSS_EVT,
  input  wire logic          DEMAG_DETECT,
  output logic               DEMAG_EVENT,
  output logic [2*NPH-1:0]   DRIVE_OUT
);
  // Register state
  logic [7:0]       dead_cfg_ff;
  logic             cfg_written_ff;
  logic             dead_insert_enable_ff;
  logic             three_pwm_mode_ff;
  logic             post_commutation_side_select_ff;
  logic             unused_output_select_bit_ff;
  logic             post_zero_cross_side_select_ff;
  logic             sensor_mode_flag_ff;
  logic             voltage_current_select_ff;
  // Bus state
  logic             aw_held_ff;
  logic             w_held_ff;
  logic [3:0]       awaddr_ff;
  logic [31:0]      wdata_ff;
  logic [3:0]       wstrb_ff;
  logic             bvalid_ff;
  logic [1:0]       bresp_ff;
  logic             rvalid_ff;
  logic [1:0]       rresp_ff;
  logic [31:0]      rdata_ff;
  // Datapath state
  logic             window_ff;
  logic [2*NPH-1:0] drive_out_ff;
  logic             demag_ff;
  logic [2*NPH-1:0] nxt_drive;
  logic [DLY_W-1:0] delay_cyc;
  logic             side_low;
  logic             wr_fire;
  logic             wr_hit;
  logic [31:0]      rd_word;
  logic             rd_hit;

  // Channels to the per-phase generators
  pwmdt_dt_if dt_ch [NPH] ();

  // Write address and data are taken independently, then combined
  assign S_AXI_AWREADY = !aw_held_ff && !bvalid_ff;
  assign S_AXI_WREADY  = !w_held_ff && !bvalid_ff;
  assign wr_fire       = aw_held_ff && w_held_ff && !bvalid_ff;
  assign wr_hit        = (awaddr_ff == REG_DEAD_CFG) || (awaddr_ff == REG_CTRL);
  assign S_AXI_BVALID  = bvalid_ff;
  assign S_AXI_BRESP   = bresp_ff;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      aw_held_ff <= 1'b0;
      w_held_ff  <= 1'b0;
      awaddr_ff  <= '0;
      wdata_ff   <= '0;
      wstrb_ff   <= '0;
    end else begin
      if (S_AXI_AWVALID && S_AXI_AWREADY) begin
        aw_held_ff <= 1'b1;
        awaddr_ff  <= {S_AXI_AWADDR[3:2], 2'h0};
      end else if (wr_fire) begin
        aw_held_ff <= 1'b0;
      end
      if (S_AXI_WVALID && S_AXI_WREADY) begin
        w_held_ff <= 1'b1;
        wdata_ff  <= S_AXI_WDATA;
        wstrb_ff  <= S_AXI_WSTRB;
      end else if (wr_fire) begin
        w_held_ff <= 1'b0;
      end
    end
  end

  // Write response
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bvalid_ff <= 1'b0;
      bresp_ff  <= RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_ff <= 1'b1;
      bresp_ff  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_BREADY) begin
      bvalid_ff <= 1'b0;
    end
  end

  // Dead time code, writable once after reset
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dead_cfg_ff    <= DEAD_CFG_RESET;                         // [RL11]
      cfg_written_ff <= 1'b0;
    end else if (wr_fire && awaddr_ff == REG_DEAD_CFG && wstrb_ff[0] && !cfg_written_ff) begin
      dead_cfg_ff    <= wdata_ff[7:0];                          // [RL10]
      cfg_written_ff <= 1'b1;
    end
  end

  // Mode and side select bits
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      dead_insert_enable_ff           <= 1'b1;
      three_pwm_mode_ff               <= 1'b1;
      post_commutation_side_select_ff <= 1'b0;
      unused_output_select_bit_ff     <= 1'b0;
      post_zero_cross_side_select_ff  <= 1'b0;
      sensor_mode_flag_ff             <= 1'b0;
      voltage_current_select_ff       <= 1'b0;
    end else if (wr_fire && awaddr_ff == REG_CTRL && wstrb_ff[0]) begin
      // Enable is locked while three-PWM mode is on
      if (!three_pwm_mode_ff) begin
        dead_insert_enable_ff <= wdata_ff[CTRL_DTE];
      end
      three_pwm_mode_ff               <= wdata_ff[CTRL_PCN];
      post_commutation_side_select_ff <= wdata_ff[CTRL_OSC];
      unused_output_select_bit_ff     <= wdata_ff[CTRL_OSU];
      post_zero_cross_side_select_ff  <= wdata_ff[CTRL_OSZ];
      sensor_mode_flag_ff             <= wdata_ff[CTRL_SENS];
      voltage_current_select_ff       <= wdata_ff[CTRL_VOC];
    end
  end

  // Read decode
  always_comb begin
    rd_word = '0;
    rd_hit  = 1'b1;
    unique case ({S_AXI_ARADDR[3:2], 2'h0})
      REG_DEAD_CFG: rd_word[7:0] = dead_cfg_ff;
      REG_CTRL: begin
        rd_word[CTRL_DTE]  = dead_insert_enable_ff;
        rd_word[CTRL_PCN]  = three_pwm_mode_ff;
        rd_word[CTRL_OSC]  = post_commutation_side_select_ff;
        rd_word[CTRL_OSU]  = unused_output_select_bit_ff;
        rd_word[CTRL_OSZ]  = post_zero_cross_side_select_ff;
        rd_word[CTRL_SENS] = sensor_mode_flag_ff;
        rd_word[CTRL_VOC]  = voltage_current_select_ff;
      end
      REG_STATUS: begin
        rd_word[2*NPH-1:0] = drive_out_ff;
        rd_word[STAT_WIN]  = window_ff;
        rd_word[STAT_WR1]  = cfg_written_ff;
      end
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel, one cycle from address to data
  assign S_AXI_ARREADY = !rvalid_ff;
  assign S_AXI_RVALID  = rvalid_ff;
  assign S_AXI_RDATA   = rdata_ff;
  assign S_AXI_RRESP   = rresp_ff;

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rvalid_ff <= 1'b0;
      rdata_ff  <= '0;
      rresp_ff  <= RESP_OKAY;
    end else if (S_AXI_ARVALID && S_AXI_ARREADY) begin
      rvalid_ff <= 1'b1;
      rdata_ff  <= rd_word;
      rresp_ff  <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (S_AXI_RREADY) begin
      rvalid_ff <= 1'b0;
    end
  end

  // Window from zero crossing to commutation; commutation wins a tie
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      window_ff <= 1'b0;
    end else if (COMMUTATION_EVT) begin
      window_ff <= 1'b0;
    end else if (ZERO_CROSS_EVT) begin
      window_ff <= 1'b1;
    end
  end

  // Side of PWM for the current part of the step
  assign side_low = window_ff ? post_zero_cross_side_select_ff     // [RL7]
                              : post_commutation_side_select_ff;   // [RL13]

  // Demagnetisation event is suppressed in sensor mode
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      demag_ff <= 1'b0;
    end else begin
      demag_ff <= DEMAG_DETECT && !sensor_mode_flag_ff;           // [RL8]
    end
  end
  assign DEMAG_EVENT = demag_ff;

  // Common delay from the code
  assign delay_cyc = pwmdt_delay_cycles(dead_cfg_ff[5:0]);       // [RL9]

  // One generator per phase and the output mux per half bridge
  for (genvar p = 0; p < NPH; p++) begin : g_ph
    logic hi_act;
    logic lo_act;
    logic pwm_hi;
    logic pwm_lo;
    assign hi_act = CHAN_ACTIVE[2*p];
    assign lo_act = CHAN_ACTIVE[2*p+1];
    assign pwm_hi = hi_act && !side_low;
    assign pwm_lo = lo_act && side_low;
    assign dt_ch[p].delay    = delay_cyc;
    assign dt_ch[p].phase_in = three_pwm_mode_ff ? PHASE_PWM[p]  // [RL2]
                             : ((pwm_hi || pwm_lo) && PHASE_PWM[0]);

    pwmdt_gen u_gen (
      .CLK     (CLK),
      .RESET_N (RESET_N),
      .dt      (dt_ch[p])
    );

    always_comb begin
      nxt_drive[2*p]   = 1'b0;
      nxt_drive[2*p+1] = 1'b0;
      if (three_pwm_mode_ff && !dead_insert_enable_ff) begin
        nxt_drive[2*p]   = PHASE_PWM[p];                         // [RL12]
        nxt_drive[2*p+1] = !PHASE_PWM[p];
      end else if (three_pwm_mode_ff) begin
        nxt_drive[2*p]   = dt_ch[p].out_a;                       // [RL1]
        nxt_drive[2*p+1] = dt_ch[p].out_b;
      end else if (!dead_insert_enable_ff) begin
        nxt_drive[2*p]   = hi_act && (pwm_hi ? PHASE_PWM[0] : 1'b1);
        nxt_drive[2*p+1] = lo_act && (pwm_lo ? PHASE_PWM[0] : 1'b1);
      end else if (pwm_hi) begin
        nxt_drive[2*p]   = dt_ch[p].out_a;                       // [RL3]
        nxt_drive[2*p+1] = dt_ch[p].out_b;
      end else if (pwm_lo) begin
        nxt_drive[2*p]   = dt_ch[p].out_b;                       // [RL3]
        nxt_drive[2*p+1] = dt_ch[p].out_a;
      end else begin
        nxt_drive[2*p]   = hi_act && !lo_act;
        nxt_drive[2*p+1] = lo_act && !hi_act;
      end
    end
  end

  // Registered drive outputs
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      drive_out_ff <= '0;
    end else begin
      drive_out_ff <= nxt_drive;
    end
  end
  assign DRIVE_OUT = drive_out_ff;

  cfg_once_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL10]
    $past(cfg_written_ff) |-> $stable(dead_cfg_ff)) else $error("config rewritten");
  cfg_reset_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL11]
    !cfg_written_ff |-> dead_cfg_ff == DEAD_CFG_RESET) else $error("config not all ones");
  delay_range_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL9]
    dead_cfg_ff[5:4] == 2'h3 |-> delay_cyc == DLY_W'(({5'h00, dead_cfg_ff[3:0]} + 9'd17) * 8))
    else $error("coarse delay wrong");
  zc_side_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL7]
    ZERO_CROSS_EVT && !COMMUTATION_EVT |=> side_low == post_zero_cross_side_select_ff)
    else $error("zero cross side wrong");
  comm_side_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL13]
    COMMUTATION_EVT |=> side_low == post_commutation_side_select_ff)
    else $error("commutation side wrong");
  no_demag_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL8]
    $past(sensor_mode_flag_ff) |-> !DEMAG_EVENT) else $error("demag in sensor mode");
  plain_comp_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL12]
    three_pwm_mode_ff && !dead_insert_enable_ff |=> DRIVE_OUT[1] == !DRIVE_OUT[0])
    else $error("low side not complement");
  no_shoot_a: assert property (@(posedge CLK) disable iff (!RESET_N) // [RL1]
    dead_insert_enable_ff |=> !(DRIVE_OUT[0] && DRIVE_OUT[1])) else $error("shoot-through");
endmodule : pwmdt_top
`default_nettype wire

/* File: verification/pwm_dead_time_generator_tb_top.sv */
`default_nettype none
module pwm_dead_time_generator_tb_top
  import pwmdt_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic [3:0]  aw_addr = 4'h0;
  logic        aw_valid = 1'b0;
  logic [31:0] w_data = 32'h0000_0000;
  logic        w_valid = 1'b0;
  logic        b_ready = 1'b0;
  logic [3:0]  ar_addr = 4'h0;
  logic        ar_valid = 1'b0;
  logic        r_ready = 1'b0;
  logic [2:0]  phase = 3'h0;
  logic [5:0]  chan_act = 6'h3F;
  logic        comm_evt = 1'b0;
  logic        zc_evt = 1'b0;
  logic        demag_det = 1'b0;
  logic        aw_ready, w_ready, b_valid, ar_ready, r_valid, demag_evt;
  logic [1:0]  b_resp, r_resp;
  logic [31:0] r_data;
  logic [5:0]  drive;
  logic [15:0] overlap;
  int          n_fail = 0;
  int          checks_done = 0;
  logic [5:0]  codes [7] = '{6'h00, 6'h0F, 6'h1F, 6'h20, 6'h2F, 6'h30, 6'h3F};
  int          dly   [7] = '{2, 32, 64, 68, 128, 136, 256};

  always #10 clk = ~clk;

  pwmdt_top dut_u (
    .CLK(clk), .RESET_N(rst_n),
    .S_AXI_AWADDR(aw_addr), .S_AXI_AWVALID(aw_valid), .S_AXI_AWREADY(aw_ready),
    .S_AXI_WDATA(w_data), .S_AXI_WSTRB(4'hF), .S_AXI_WVALID(w_valid),
    .S_AXI_WREADY(w_ready), .S_AXI_BRESP(b_resp), .S_AXI_BVALID(b_valid),
    .S_AXI_BREADY(b_ready), .S_AXI_ARADDR(ar_addr), .S_AXI_ARVALID(ar_valid),
    .S_AXI_ARREADY(ar_ready), .S_AXI_RDATA(r_data), .S_AXI_RRESP(r_resp),
    .S_AXI_RVALID(r_valid), .S_AXI_RREADY(r_ready), .PHASE_PWM(phase),
    .CHAN_ACTIVE(chan_act), .COMMUTATION_EVT(comm_evt), .ZERO_CROSS_EVT(zc_evt),
    .DEMAG_DETECT(demag_det), .DEMAG_EVENT(demag_evt), .DRIVE_OUT(drive)
  );

  pwmdt_bridge_model bridge_u (.clk(clk), .gate(drive), .overlap_cnt(overlap));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic end_of_test();
    $display("Checks %0d, mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : end_of_test

  task automatic axi_write(input logic [3:0] a, input logic [31:0] d, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge clk);
    aw_addr  <= a;
    w_data   <= d;
    aw_valid <= 1'b1;
    w_valid  <= 1'b1;
    b_ready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (aw_valid && aw_ready) aw_valid <= 1'b0;
      if (w_valid && w_ready) w_valid <= 1'b0;
    end while (!b_valid);
    b_ready <= 1'b0;
    rsp = b_resp;
    check(32'(n), 32'h0000_0003, "write answer");
  endtask : axi_write

  task automatic axi_read(input logic [3:0] a, output logic [31:0] d, output logic [1:0] rsp);
    int n;
    n = 0;
    @(posedge clk);
    ar_addr  <= a;
    ar_valid <= 1'b1;
    r_ready  <= 1'b1;
    do begin
      @(posedge clk);
      n++;
      if (ar_valid && ar_ready) ar_valid <= 1'b0;
    end while (!r_valid);
    r_ready <= 1'b0;
    d = r_data;
    rsp = r_resp;
    check(32'(n), 32'h0000_0002, "read answer");
  endtask : axi_read

  // Counts edges until one drive line reaches a level
  task automatic wait_lvl(input int b, input logic lvl, output int n);
    n = 0;
    do begin
      @(posedge clk);
      #1;
      n++;
    end while (drive[b] !== lvl);
  endtask : wait_lvl

  task automatic do_reset();
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic pulse_evt(input logic zc);
    @(posedge clk);
    if (zc) zc_evt <= 1'b1;
    else comm_evt <= 1'b1;
    @(posedge clk);
    zc_evt   <= 1'b0;
    comm_evt <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
  endtask : pulse_evt

  // Main sequence
  initial begin
    logic [1:0]  rsp;
    logic [31:0] rd;
    int          n, m, p, hits;
    do_reset();
    axi_read(REG_DEAD_CFG, rd, rsp);
    check(rd, 32'h0000_00FF, "config reset");
    axi_read(REG_CTRL, rd, rsp);
    check(rd, 32'h0000_0003, "control reset");
    axi_read(4'hC, rd, rsp);
    check({rd[29:0], rsp}, {30'h0000_0000, RESP_SLVERR}, "unmapped read");
    axi_write(4'hC, 32'h0000_0001, rsp);
    check(32'(rsp), 32'(RESP_SLVERR), "unmapped write");
    $display("Test registers done");
    for (int i = 0; i < 7; i++) begin
      p = i % 3;
      do_reset();
      axi_write(REG_DEAD_CFG, {26'h000_0000, codes[i]}, rsp);
      wait_lvl(2 * p + 1, 1'b1, n);
      @(posedge clk);
      phase[p] <= 1'b1;
      wait_lvl(2 * p + 1, 1'b0, n);
      check(32'(n <= 2), 32'h0000_0001, "low side off");
      wait_lvl(2 * p, 1'b1, m);
      check(32'(n + m), 32'(dly[i] + 1), "high side delayed");
      @(posedge clk);
      phase[p] <= 1'b0;
      wait_lvl(2 * p, 1'b0, n);
      check(32'(n <= 2), 32'h0000_0001, "high side off");
      wait_lvl(2 * p + 1, 1'b1, m);
      check(32'(n + m), 32'(dly[i] + 1), "low side delayed");
    end
    $display("Test delay codes done");
    do_reset();
    axi_write(REG_DEAD_CFG, 32'h0000_0001, rsp);
    axi_write(REG_DEAD_CFG, 32'h0000_003F, rsp);
    check(32'(rsp), 32'(RESP_OKAY), "second write answer");
    axi_read(REG_DEAD_CFG, rd, rsp);
    check(rd, 32'h0000_0001, "second write ignored");
    axi_read(REG_STATUS, rd, rsp);
    check(32'(rd[STAT_WR1]), 32'h0000_0001, "written flag");
    // Input pulse of three cycles against a four cycle delay
    wait_lvl(1, 1'b1, n);
    @(posedge clk);
    phase[0] <= 1'b1;
    repeat (3) @(posedge clk);
    phase[0] <= 1'b0;
    hits = 0;
    repeat (12) begin
      @(posedge clk);
      #1;
      if (drive[0] !== 1'b0) hits++;
    end
    check(32'(hits), 32'h0000_0000, "short pulse dropped");
    $display("Test write once and short pulse done");
    axi_write(REG_CTRL, 32'h0000_0001, rsp);
    chan_act <= 6'h01;
    phase[0] <= 1'b1;
    repeat (10) @(posedge clk);
    #1;
    check(32'(drive), 32'h0000_0001, "six step driven on");
    @(posedge clk);
    phase[0] <= 1'b0;
    repeat (10) @(posedge clk);
    #1;
    check(32'(drive), 32'h0000_0002, "six step rectify");
    @(posedge clk);
    chan_act <= 6'h03;
    for (int k = 0; k < 2; k++) begin
      axi_write(REG_CTRL, k ? 32'h0000_0004 : 32'h0000_0010, rsp);
      pulse_evt(1'b0);
      check(32'(drive), 32'(k ? 6'h01 : 6'h02), "after commutation");
      pulse_evt(1'b1);
      check(32'(drive), 32'(k ? 6'h02 : 6'h01), "after zero cross");
    end
    $display("Test six step done");
    axi_write(REG_CTRL, 32'h0000_0002, rsp);
    axi_write(REG_CTRL, 32'h0000_0003, rsp);
    axi_read(REG_CTRL, rd, rsp);
    check(rd, 32'h0000_0002, "enable locked");
    chan_act <= 6'h3F;
    @(posedge clk);
    phase <= 3'b101;
    @(posedge clk);
    #1;
    check(32'(drive), 32'h0000_0019, "plain complement");
    $display("Test three pwm done");
    axi_write(REG_CTRL, 32'h0000_0022, rsp);
    demag_det <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    check(32'(demag_evt), 32'h0000_0000, "sensor demag");
    axi_write(REG_CTRL, 32'h0000_0002, rsp);
    repeat (3) @(posedge clk);
    #1;
    check(32'(demag_evt), 32'h0000_0001, "sensorless demag");
    // Loose select bits read back, status shows drive, window and lock
    axi_write(REG_CTRL, 32'h0000_004A, rsp);
    axi_read(REG_CTRL, rd, rsp);
    check(rd, 32'h0000_004A, "loose select bits");
    axi_read(REG_STATUS, rd, rsp);
    check(rd, 32'h0000_00D9, "status word");
    check(32'(overlap), 32'h0000_0000, "leg overlap");
    $display("Test demag and overlap done");
    end_of_test();
  end

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    n_fail++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
endmodule : pwm_dead_time_generator_tb_top
`default_nettype wire

/* File: verification/pwmdt_bridge_model.sv */
`default_nettype none
module pwmdt_bridge_model (
  input  wire logic       clk,
  input  wire logic [5:0] gate,
  output logic [15:0]     overlap_cnt
);
  timeunit 1ns;
  timeprecision 1ps;
  initial overlap_cnt = 16'h0000;
  // Counts cycles where both switches of one leg conduct
  always @(posedge clk) begin
    if ((gate[0] & gate[1]) | (gate[2] & gate[3]) | (gate[4] & gate[5])) begin
      overlap_cnt <= overlap_cnt + 16'h0001;
    end
  end
endmodule : pwmdt_bridge_model
`default_nettype wire
